// ===== tcs_pkg.sv
package tcs_pkg;

  // Register byte offsets
  localparam logic [7:0] TCS_CTL_OFF = 8'h00; // timer_control_main
  localparam logic [7:0] TCS_SMC_OFF = 8'h08; // slave_mode_config

  // Reset values of both control registers
  localparam logic [15:0] TCS_CTL_RST = 16'h0000;
  localparam logic [15:0] TCS_SMC_RST = 16'h0000;

  // Field positions in timer_control_main
  localparam int TCS_CTL_RUN_POS  = 0; // counter_run
  localparam int TCS_CTL_UDIS_POS = 1; // update_suppress
  localparam int TCS_CTL_USRC_POS = 2; // update_source_select
  localparam int TCS_CTL_OSH_POS  = 3; // one_shot_enable
  localparam int TCS_CTL_RELOAD_SHADOW_ENABLE_POS = 7; // reload_shadow_enable
  localparam int TCS_CTL_DIV_POS  = 8; // sample_clock_divider, 2 bits

  // Field positions in slave_mode_config
  localparam int TCS_SMC_MODE_POS = 0; // slave_mode_select, 3 bits
  localparam int TCS_SMC_TSEL_POS = 4; // trigger_source_select, 3 bits
  localparam int TCS_SMC_SYNC_POS = 7; // sync_start_enable

  // Sample clock division codes
  localparam logic [1:0] TCS_DIV_1 = 2'h0;
  localparam logic [1:0] TCS_DIV_2 = 2'h1;
  localparam logic [1:0] TCS_DIV_4 = 2'h2;

  // Reserved trigger source code
  localparam logic [2:0] TCS_TSEL_RSVD = 3'h7;

  // Slave mode encodings
  typedef enum logic [2:0] {
    TCS_SM_OFF     = 3'b000,
    TCS_SM_RSVD1   = 3'b001,
    TCS_SM_RSVD2   = 3'b010,
    TCS_SM_RSVD3   = 3'b011,
    TCS_SM_RESTART = 3'b100,
    TCS_SM_PAUSE   = 3'b101,
    TCS_SM_EVENT   = 3'b110,
    TCS_SM_EXTCLK  = 3'b111
  } tcs_smode_e;

  // Writable control fields of timer_control_main
  typedef struct packed {
    logic [1:0] div;
    logic       reload_shadow_enable;
    logic       osh;
    logic       usrc;
    logic       udis;
    logic       run;
  } tcs_ctl_s;

  // Writable fields of slave_mode_config
  typedef struct packed {
    logic       sync;
    logic [2:0] tsel;
    tcs_smode_e mode;
  } tcs_smc_s;

endpackage : tcs_pkg

// ===== tcs_timer_ctrl.sv
// Behaviour
// (R1) Divider code sets sample clock: 1,1/2,1/4
// (R2) Shadow enable buffers reload until update
// (R3) One-shot counts only until next update
// (R4) Source select 0: all updates raise request
// (R5) Source select 1: only overflow raises request
// (R6) Update loads preloaded reload value
// (R7) Suppress blocks update, reinit still happens
// (R8) Software sets run for pause, external modes
// (R9) Sync start forwards trigger as start event
// (R10) Trigger select picks one of seven inputs
// (R11) Software keeps trigger select while slave active
// (R12) Mode off: counts on clock while run
// (R13) Restart: trigger edge reinits, makes update
// (R14) Pause: counter clock gated by trigger level
// (R15) Event: trigger rising edge starts counter
// (R16) External clock: counts on trigger edges
// (R17) One-shot: update stops, trigger edge starts
// (R18) Trigger flag on events; pause both edges
// (R19) Reserved codes give no trigger behaviour
// (R20) Reserved bits read zero, ignore writes
module tcs_timer_ctrl
  import tcs_pkg::*;
#(
  parameter int CNT_W = 16   // Counter and reload width
)(
  input  wire logic             clk_sys_in,
  input  wire logic             reset_n_in,
  input  wire logic [7:0]       reg_addr_in,
  input  wire logic [15:0]      reg_wdata_in,
  input  wire logic             reg_wr_in,
  input  wire logic             reg_rd_in,
  output logic      [15:0]      reg_rdata_out,
  input  wire logic             reload_wr_in,
  input  wire logic [CNT_W-1:0] reload_data_in,
  input  wire logic             sw_update_in,
  input  wire logic             trig_flag_clr_in,
  input  wire logic [3:0]       internal_trigger_in,
  input  wire logic             chan0_edge_detect_in,
  input  wire logic             chan0_filtered_input_in,
  input  wire logic             chan1_filtered_input_in,
  output logic [CNT_W-1:0]      counter_out,
  output logic                  update_event_out,
  output logic                  update_request_out,
  output logic                  trigger_flag_out,
  output logic                  trigger_output_out,
  output logic                  deadtime_sample_tick_out
);

  // Refuse widths the 16-bit register view cannot carry
  if (CNT_W < 2 || CNT_W > 16)
  begin : g_width_check
    $error("tcs_timer_ctrl: CNT_W must be 2 to 16");
  end

  tcs_ctl_s         ctl;          // Control register fields
  tcs_smc_s         slave_mode_select;          // Slave mode register fields
  logic [CNT_W-1:0] arr_active;   // Reload value in use
  logic [CNT_W-1:0] arr_preload;  // Reload value written by software
  logic             trig_q;       // Previous selected trigger level
  logic [1:0]       div_cnt;      // Sample clock divider count
  logic             trig_sel;     // selected_trigger_input
  logic             trig_rise;    // Rising edge of the trigger
  logic             trig_fall;    // Falling edge of the trigger
  logic             slave_on;     // A documented slave mode is active
  logic             restart_hit;  // Restart-mode trigger
  logic             start_hit;    // Trigger that sets counter_run
  logic             tick;         // Counter advance enable
  logic             overflow;     // Counter reached reload value
  logic             reinit;       // Counter reinit to zero
  logic             upd_evt;      // Update event this cycle
  logic             trig_evt;     // Trigger event for the flag
  logic             wr_ctl;       // Write to timer_control_main
  logic             wr_smc;       // Write to slave_mode_config

  assign wr_ctl = reg_wr_in && (reg_addr_in == TCS_CTL_OFF);
  assign wr_smc = reg_wr_in && (reg_addr_in == TCS_SMC_OFF);

  // Trigger multiplexer; reserved code yields a quiet low
  always_comb
  begin
    case (slave_mode_select.tsel) inside
      [3'h0:3'h3]: trig_sel = internal_trigger_in[slave_mode_select.tsel[1:0]];     // R10
      3'h4:    trig_sel = chan0_edge_detect_in;                      // R10
      3'h5:    trig_sel = chan0_filtered_input_in;                   // R10
      3'h6:    trig_sel = chan1_filtered_input_in;                   // R10
      default: trig_sel = 1'b0;                                      // R19
    endcase
  end

  // Previous trigger level for edge detection
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      trig_q <= 1'b0;
    else
      trig_q <= trig_sel;
  end

  assign trig_rise = trig_sel && !trig_q;
  assign trig_fall = !trig_sel && trig_q;

  // Reserved slave codes act like mode off, with no trigger action
  assign slave_on    = slave_mode_select.mode[2];                                  // R19
  assign restart_hit = (slave_mode_select.mode == TCS_SM_RESTART) && trig_rise;    // R13
  // Event mode starts the counter; in one-shot a restart edge does too
  assign start_hit   = trig_rise &&
                       ((slave_mode_select.mode == TCS_SM_EVENT) ||                // R15
                        (ctl.osh && slave_mode_select.mode == TCS_SM_RESTART));    // R17

  // Counter clock per slave mode; pause and external need run set
  always_comb
  begin
    case (slave_mode_select.mode)
      TCS_SM_PAUSE:  tick = ctl.run && trig_sel;                     // R14 R8
      TCS_SM_EXTCLK: tick = ctl.run && trig_rise;                    // R16 R8
      default:       tick = ctl.run;                                 // R12
    endcase
  end

  assign overflow = tick && (counter_out == arr_active);
  assign reinit   = sw_update_in || restart_hit;                     // R7
  assign upd_evt  = !ctl.udis && (overflow || reinit);               // R7
  // Pause counts both edges as trigger events, other active slave modes one
  assign trig_evt = slave_on &&
                    (trig_rise ||
                     (slave_mode_select.mode == TCS_SM_PAUSE && trig_fall));       // R18

  // Control register; hardware start wins over the one-shot stop
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      ctl <= tcs_ctl_s'(TCS_CTL_RST);
    else
    begin
      if (wr_ctl)
      begin
        // Only documented fields are kept, reserved bits dropped
        ctl.div  <= reg_wdata_in[TCS_CTL_DIV_POS +: 2];              // R20
        ctl.reload_shadow_enable <= reg_wdata_in[TCS_CTL_RELOAD_SHADOW_ENABLE_POS];
        ctl.osh  <= reg_wdata_in[TCS_CTL_OSH_POS];
        ctl.usrc <= reg_wdata_in[TCS_CTL_USRC_POS];
        ctl.udis <= reg_wdata_in[TCS_CTL_UDIS_POS];
        ctl.run  <= reg_wdata_in[TCS_CTL_RUN_POS];
      end
      if (ctl.osh && upd_evt)
        ctl.run <= 1'b0;                                             // R3 R17
      if (start_hit)
        ctl.run <= 1'b1;                                             // R15 R17
    end
  end

  // Slave mode register; the field is not locked in hardware
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      slave_mode_select <= tcs_smc_s'(TCS_SMC_RST[7:0]);
    else if (wr_smc)
    begin
      // Software must leave tsel alone while a slave mode runs
      slave_mode_select.sync <= reg_wdata_in[TCS_SMC_SYNC_POS];                    // R11
      slave_mode_select.tsel <= reg_wdata_in[TCS_SMC_TSEL_POS +: 3];
      slave_mode_select.mode <= tcs_smode_e'(reg_wdata_in[TCS_SMC_MODE_POS +: 3]);
    end
  end

  // Reload value, direct or through the preload copy
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      arr_preload <= '1;
      arr_active  <= '1;
    end
    else
    begin
      if (upd_evt)
        arr_active <= arr_preload;                                   // R6
      if (reload_wr_in)
      begin
        arr_preload <= reload_data_in;                               // R2
        if (!ctl.reload_shadow_enable)
          arr_active <= reload_data_in;                              // R2
      end
    end
  end

  // Counter; reinit beats wrap, wrap beats advance
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      counter_out <= '0;
    else if (reinit || overflow)
      counter_out <= '0;                                             // R13 R7
    else if (tick)
      counter_out <= counter_out + 1'b1;                             // R12
  end

  // Update event and update request pulses
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      update_event_out   <= 1'b0;
      update_request_out <= 1'b0;
    end
    else
    begin
      update_event_out   <= upd_evt;                                 // R13
      // Overflow asks unless udis is set; software and restart only when usrc=0
      update_request_out <= upd_evt && (!ctl.usrc || overflow);      // R4 R5
    end
  end

  // Trigger flag: an event in the clear cycle still sets it
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      trigger_flag_out <= 1'b0;
    else if (trig_evt)
      trigger_flag_out <= 1'b1;                                      // R18
    else if (trig_flag_clr_in)
      trigger_flag_out <= 1'b0;
  end

  // Trigger output: the start event when syncing, else updates
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      trigger_output_out <= 1'b0;
    else if (slave_mode_select.sync)
      trigger_output_out <= trig_rise && slave_on;                   // R9
    else
      trigger_output_out <= upd_evt;
  end

  // Sample clock enable; reserved divider code runs undivided
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      div_cnt                  <= 2'h0;
      deadtime_sample_tick_out <= 1'b0;
    end
    else
    begin
      div_cnt <= div_cnt + 2'h1;
      case (ctl.div)
        TCS_DIV_2: deadtime_sample_tick_out <= div_cnt[0];           // R1
        TCS_DIV_4: deadtime_sample_tick_out <= (div_cnt == 2'h3);    // R1
        default:   deadtime_sample_tick_out <= 1'b1;                 // R1
      endcase
    end
  end

  // Register read port; unmapped addresses read zero
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      reg_rdata_out <= 16'h0000;
    else if (reg_rd_in)
    begin
      reg_rdata_out <= 16'h0000;                                     // R20
      if (reg_addr_in == TCS_CTL_OFF)
      begin
        reg_rdata_out[TCS_CTL_DIV_POS +: 2] <= ctl.div;
        reg_rdata_out[TCS_CTL_RELOAD_SHADOW_ENABLE_POS]     <= ctl.reload_shadow_enable;
        reg_rdata_out[TCS_CTL_OSH_POS]      <= ctl.osh;
        reg_rdata_out[TCS_CTL_USRC_POS]     <= ctl.usrc;
        reg_rdata_out[TCS_CTL_UDIS_POS]     <= ctl.udis;
        reg_rdata_out[TCS_CTL_RUN_POS]      <= ctl.run;
      end
      else if (reg_addr_in == TCS_SMC_OFF)
        reg_rdata_out[7:0] <= {slave_mode_select.sync, slave_mode_select.tsel, 1'b0, slave_mode_select.mode};
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  div_quarter_a: assert property ( // R1
    ctl.div == TCS_DIV_4 ##1 ctl.div == TCS_DIV_4 && deadtime_sample_tick_out
    ##1 ctl.div == TCS_DIV_4 [*2] |-> $past(!deadtime_sample_tick_out)
    && !deadtime_sample_tick_out ##1 !deadtime_sample_tick_out)
    else $error("quarter sample tick too frequent");
  preload_hold_a: assert property ( // R2
    ctl.reload_shadow_enable && reload_wr_in && !upd_evt |=> $stable(arr_active))
    else $error("buffered reload took effect early");
  shadow_load_a: assert property ( // R6
    upd_evt && !reload_wr_in |=> arr_active == $past(arr_preload))
    else $error("update did not load reload value");
  oneshot_stop_a: assert property ( // R17
    ctl.osh && upd_evt && !start_hit |=> !ctl.run)
    else $error("one-shot kept running after update");
  src_all_a: assert property ( // R4
    !ctl.usrc && upd_evt |=> update_request_out)
    else $error("update request missing");
  src_ovf_a: assert property ( // R5
    ctl.usrc && upd_evt && !overflow |=> !update_request_out)
    else $error("non-overflow update raised request");
  suppress_init_a: assert property ( // R7
    ctl.udis && sw_update_in |=> counter_out == '0 && !update_event_out)
    else $error("suppressed update wrong");
  restart_upd_a: assert property ( // R13
    restart_hit && !ctl.udis |=> update_event_out && counter_out == '0)
    else $error("restart did not reinit and update");
  off_count_a: assert property ( // R12
    slave_mode_select.mode == TCS_SM_OFF && tick && !overflow && !reinit
    |=> counter_out == $past(counter_out) + 1'b1)
    else $error("counter did not advance");
  pause_hold_a: assert property ( // R14
    slave_mode_select.mode == TCS_SM_PAUSE && !trig_sel && !reinit |=> $stable(counter_out))
    else $error("counter moved while paused");
  event_start_a: assert property ( // R15
    slave_mode_select.mode == TCS_SM_EVENT && trig_rise |=> ctl.run)
    else $error("event trigger did not start counter");
  ext_hold_a: assert property ( // R16
    slave_mode_select.mode == TCS_SM_EXTCLK && !trig_rise && !reinit
    |=> $stable(counter_out))
    else $error("external clock counted without edge");
  sync_out_a: assert property ( // R9
    slave_mode_select.sync && slave_on && trig_rise |=> trigger_output_out)
    else $error("start event not forwarded");
  tsel_rsvd_a: assert property ( // R19
    slave_mode_select.tsel == TCS_TSEL_RSVD |-> !trig_sel)
    else $error("reserved trigger source active");
  trig_flag_a: assert property ( // R18
    trig_evt |=> trigger_flag_out)
    else $error("trigger flag not set");
  rsvd_read_a: assert property ( // R20
    reg_rd_in && reg_addr_in == TCS_CTL_OFF
    |=> reg_rdata_out[15:10] == 6'h00 && reg_rdata_out[6:4] == 3'h0)
    else $error("reserved bits read nonzero");

  restart_seen_c: cover property (restart_hit && !ctl.udis);
  pause_both_c:   cover property (slave_mode_select.mode == TCS_SM_PAUSE && trig_fall);
  oneshot_c:      cover property (ctl.osh && upd_evt ##1 start_hit);
  buffered_c:     cover property (ctl.reload_shadow_enable && reload_wr_in ##[1:20] upd_evt);

endmodule : tcs_timer_ctrl

// ===== tcs_trig_model.sv
// Far-side trigger sources: internal triggers and filtered channel levels
module tcs_trig_model
  import tcs_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic [2:0] sel_in,
  input  wire logic       level_in,
  input  wire logic [6:0] noise_in,
  output logic      [3:0] internal_trigger_out,
  output logic            chan0_edge_detect_out,
  output logic            chan0_filtered_input_out,
  output logic            chan1_filtered_input_out
);
  logic [6:0] lines; // One bit per source, in select-code order

  initial lines = 7'h00;

  // Unselected sources toggle at random, so a wrong select shows up fast
  always @(posedge clk_sys_in)
  begin
    lines <= noise_in;
    if (sel_in != TCS_TSEL_RSVD)
      lines[sel_in] <= level_in;
  end

  assign internal_trigger_out     = lines[3:0];
  assign chan0_edge_detect_out    = lines[4];
  assign chan0_filtered_input_out = lines[5];
  assign chan1_filtered_input_out = lines[6];
endmodule : tcs_trig_model

// ===== tb_timer_control_slave_mode.sv
`define CHK(a, b) \
  begin \
    cmp_count++; \
    if ((a) !== (b)) \
    begin \
      n_errors++; \
      $display("wrong value at %0t: got %h want %h", $time, a, b); \
    end \
  end

module tb_timer_control_slave_mode
  import tcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys_in, reset_n_in, reg_wr_in, reg_rd_in;
  logic [7:0]  reg_addr_in;
  logic [15:0] reg_wdata_in, reg_rdata_out, reload_data_in, counter_out;
  logic        reload_wr_in, sw_update_in, trig_flag_clr_in;
  logic [3:0]  iti;
  logic        c0_ed, c0_f, c1_f, upd_o, req_o, flag_o, trigger_output_o, tick_o;
  logic        lvl;                        // Level of the selected source
  logic [6:0]  noise;                      // Noise on the other sources
  logic [2:0]  cur_tsel, md_t;
  logic [31:0] r;
  logic [3:0]  ticks;
  int          seed, n_errors, cmp_count, cyc, it;
  // Reference model state; blocking updates keep it one flat step per edge
  logic [15:0] m_ctl, m_smc, m_act, m_pre, m_cnt, e_rd;
  logic [6:0]  lines;
  logic [2:0]  md;
  logic        trg, rise, fall, inc, ovf, upd, reinit, m_prev;
  logic        e_upd, e_req, e_flag, e_trigger_output, rd_v, stp, sta;

  tcs_timer_ctrl #(.CNT_W(16)) i_dut (
    .clk_sys_in               (clk_sys_in),
    .reset_n_in               (reset_n_in),
    .reg_addr_in              (reg_addr_in),
    .reg_wdata_in             (reg_wdata_in),
    .reg_wr_in                (reg_wr_in),
    .reg_rd_in                (reg_rd_in),
    .reg_rdata_out            (reg_rdata_out),
    .reload_wr_in             (reload_wr_in),
    .reload_data_in           (reload_data_in),
    .sw_update_in             (sw_update_in),
    .trig_flag_clr_in         (trig_flag_clr_in),
    .internal_trigger_in      (iti),
    .chan0_edge_detect_in     (c0_ed),
    .chan0_filtered_input_in  (c0_f),
    .chan1_filtered_input_in  (c1_f),
    .counter_out              (counter_out),
    .update_event_out         (upd_o),
    .update_request_out       (req_o),
    .trigger_flag_out         (flag_o),
    .trigger_output_out       (trigger_output_o),
    .deadtime_sample_tick_out (tick_o)
  );

  tcs_trig_model i_src (
    .clk_sys_in               (clk_sys_in),
    .sel_in                   (cur_tsel),
    .level_in                 (lvl),
    .noise_in                 (noise),
    .internal_trigger_out     (iti),
    .chan0_edge_detect_out    (c0_ed),
    .chan0_filtered_input_out (c0_f),
    .chan1_filtered_input_out (c1_f)
  );

  // Free-running 250 MHz clock
  initial
  begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  // Behavioural model, sampling the same inputs the design sees
  always @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      {m_ctl, m_smc, m_cnt} = {TCS_CTL_RST, TCS_SMC_RST, 16'h0000};
      {m_act, m_pre} = {16'hffff, 16'hffff};
      {e_upd, e_req, e_flag, e_trigger_output, m_prev, rd_v} = 6'h00;
    end
    else
    begin
      lines = {c1_f, c0_f, c0_ed, iti};
      md = m_smc[2:0];
      trg = (m_smc[6:4] == TCS_TSEL_RSVD) ? 1'b0 : lines[m_smc[6:4]];
      rise = trg & ~m_prev;
      fall = ~trg & m_prev;
      rd_v = reg_rd_in;
      e_rd = (reg_addr_in == TCS_CTL_OFF) ? m_ctl :
             (reg_addr_in == TCS_SMC_OFF) ? m_smc : 16'h0000;
      reinit = sw_update_in | (md == TCS_SM_RESTART & rise);
      inc = m_ctl[0] & ((md == TCS_SM_PAUSE) ? trg :
            (md == TCS_SM_EXTCLK) ? rise : 1'b1);
      ovf = inc & (m_cnt == m_act);
      upd = (reinit | ovf) & ~m_ctl[1];
      e_req = upd & (ovf | ~m_ctl[2]);
      e_upd = upd;
      e_trigger_output = m_smc[7] ? (rise & md[2]) : upd;
      if (reinit | ovf)
        m_cnt = 16'h0000;
      else if (inc)
        m_cnt = m_cnt + 16'h0001;
      if (upd)
        m_act = m_pre;
      if (reload_wr_in)
        m_pre = reload_data_in;
      if (reload_wr_in & ~m_ctl[7])
        m_act = reload_data_in;
      // Hardware stop and start decide on the old fields and beat a write
      stp = upd & m_ctl[3];
      sta = rise & (md == TCS_SM_EVENT | (md == TCS_SM_RESTART & m_ctl[3]));
      if (reg_wr_in & reg_addr_in == TCS_CTL_OFF)
        m_ctl = reg_wdata_in & 16'h038f;
      if (stp)
        m_ctl[0] = 1'b0;
      if (sta)
        m_ctl[0] = 1'b1;
      if (trig_flag_clr_in)
        e_flag = 1'b0;
      if (md[2] & (rise | (md == TCS_SM_PAUSE & fall)))
        e_flag = 1'b1;
      if (reg_wr_in & reg_addr_in == TCS_SMC_OFF)
        m_smc = reg_wdata_in & 16'h00f7;
      m_prev = trg;
    end
  end

  // Outputs are settled by the falling edge
  always @(negedge clk_sys_in)
  begin
    if (reset_n_in)
    begin
      `CHK(counter_out, m_cnt)
      `CHK(upd_o, e_upd)
      `CHK(req_o, e_req)
      `CHK(flag_o, e_flag)
      `CHK(trigger_output_o, e_trigger_output)
      if (rd_v)
        `CHK(reg_rdata_out, e_rd)
    end
  end

  // Hang guard, well above the roughly 3100 cycles the run needs
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  // One-cycle register access; the read result is checked by the monitor
  task automatic reg_op(input logic w, input logic [7:0] a,
                        input logic [15:0] d);
    @(posedge clk_sys_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= w;
    reg_rd_in    <= ~w;
    @(posedge clk_sys_in);
    reg_wr_in    <= 1'b0;
    reg_rd_in    <= 1'b0;
  endtask : reg_op

  // Reload write or software update pulse, kept apart from counter wraps
  task automatic poke(input logic rel, input logic [15:0] d);
    @(posedge clk_sys_in);
    reload_data_in <= d;
    reload_wr_in   <= rel;
    sw_update_in   <= ~rel;
    @(posedge clk_sys_in);
    reload_wr_in   <= 1'b0;
    sw_update_in   <= 1'b0;
  endtask : poke

  initial
  begin
    {reset_n_in, reg_wr_in, reg_rd_in, reload_wr_in, sw_update_in} = '0;
    {trig_flag_clr_in, lvl, noise, cur_tsel, cyc} = '0;
    {reg_addr_in, reg_wdata_in, reload_data_in} = '0;
    {n_errors, cmp_count} = '0;
    seed = 32'h6976;
    repeat (5) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    // Reset values, unmapped place, reserved bits
    reg_op(1'b0, TCS_CTL_OFF, 16'h0000);
    reg_op(1'b0, TCS_SMC_OFF, 16'h0000);
    reg_op(1'b0, 8'h04, 16'h0000);
    reg_op(1'b1, TCS_CTL_OFF, 16'hffff);
    reg_op(1'b0, TCS_CTL_OFF, 16'h0000);
    reg_op(1'b1, TCS_SMC_OFF, 16'hffff);
    reg_op(1'b0, TCS_SMC_OFF, 16'h0000);
    reg_op(1'b1, TCS_SMC_OFF, 16'h0000);
    reg_op(1'b1, TCS_CTL_OFF, 16'h0000);
    poke(1'b0, 16'h0000);
    poke(1'b1, 16'h0005);
    // Every slave mode against every trigger source
    for (it = 0; it < 64; it++)
    begin
      r = $random(seed);
      md_t = it[2:0] ^ 3'h4;
      cur_tsel <= it[5:3];
      lvl <= 1'b0;
      // Slave mode is off while the source changes
      reg_op(1'b1, TCS_SMC_OFF, {8'h00, r[0], it[5:3], 4'h0});
      reg_op(1'b1, TCS_CTL_OFF,
             {12'h000, r[1], 1'b0, r[2] & ~r[1], md_t != 3'h6});
      reg_op(1'b1, TCS_SMC_OFF, {8'h00, r[0], it[5:3], 1'b0, md_t});
      repeat (40)
      begin
        @(posedge clk_sys_in);
        r = $random(seed);
        if (r[1:0] == 2'b00)
          lvl <= ~lvl;
        trig_flag_clr_in <= (r[4:2] == 3'h0);
        noise <= r[14:8];
      end
      trig_flag_clr_in <= 1'b0;
    end
    // Shadowed reload under each update source and suppress setting
    reg_op(1'b1, TCS_SMC_OFF, 16'h0000);
    for (it = 0; it < 4; it++)
    begin
      reg_op(1'b1, TCS_CTL_OFF, {8'h00, 1'b1, 4'h0, it[0], it[1], 1'b0});
      poke(1'b1, 16'h0003 + it[15:0]);
      poke(1'b0, 16'h0000);
      reg_op(1'b1, TCS_CTL_OFF, {8'h00, 1'b1, 4'h0, it[0], it[1], 1'b1});
      repeat (12) @(posedge clk_sys_in);
    end
    // Sample tick density over eight cycles for each divider code
    for (it = 0; it < 4; it++)
    begin
      reg_op(1'b1, TCS_CTL_OFF, {6'h00, it[1:0], 8'h00});
      repeat (4) @(posedge clk_sys_in);
      ticks = 4'h0;
      repeat (8)
      begin
        @(negedge clk_sys_in);
        ticks = ticks + {3'b000, tick_o};
      end
      `CHK(ticks, (it == 1) ? 4'h4 : (it == 2) ? 4'h2 : 4'h8)
    end
    wrap_up();
  end
endmodule : tb_timer_control_slave_mode
